// ---- nonvolatile_memory_controller.v ----
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_defs.vh"

module nonvolatile_memory_controller #(
  parameter        SECURE_EXT = 1,
  parameter        PB_WORDS   = 16,
  parameter        PB_IDX_W   = 4,
  parameter [23:0] NS_APP_LO  = 24'h002000,
  parameter [23:0] NS_APP_HI  = 24'h004000,
  parameter [23:0] NS_DATA_LO = 24'h400400,
  parameter [23:0] NS_DATA_HI = 24'h400800,
  parameter [23:0] DATA_BASE  = 24'h400000
) (
  // clock and reset
  input  wire                clk_i,
  input  wire                reset_n_i,
  // apb slave
  input  wire                psel_i,
  input  wire                penable_i,
  input  wire                pwrite_i,
  input  wire [7:0]          paddr_i,
  input  wire [31:0]         pwdata_i,
  input  wire [2:0]          pprot_i,
  output wire [31:0]         prdata_o,
  output wire                pready_o,
  output wire                pslverr_o,
  // ahb page buffer write port
  input  wire                pb_hsel_i,
  input  wire [1:0]          pb_htrans_i,
  input  wire                pb_hwrite_i,
  input  wire [31:0]         pb_haddr_i,
  input  wire                pb_hnonsec_i,
  input  wire [31:0]         pb_hwdata_i,
  input  wire                pb_hready_i,
  output wire                pb_hreadyout_o,
  output wire                pb_hresp_o,
  // page buffer read by the flash array
  input  wire [PB_IDX_W-1:0] pb_rd_idx_i,
  output wire [31:0]         pb_rd_data_o,
  // system inputs
  input  wire                acc_wprot_i,
  input  wire                debug_halt_i,
  input  wire                tamper_event_i,
  input  wire                autow_event_i,
  // flash array operation port
  output wire                flash_start_o,
  output wire [7:0]          flash_cmd_o,
  output wire [23:0]         flash_addr_o,
  output wire                flash_data_sel_o,
  input  wire                flash_done_i,
  input  wire                flash_fail_i,
  // read path and timing
  output wire                cache_bypass_o,
  output wire [3:0]          wait_states_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function is_mapped;
    input [7:0] off;
    begin
      is_mapped = (off == `NVM_OFF_CTRL1) || (off == `NVM_OFF_CTRLB) ||
                  (off == `NVM_OFF_CTRL3) || (off == `NVM_OFF_IFLAG) ||
                  (off == `NVM_OFF_STATUS) || (off == `NVM_OFF_NSCFG) ||
                  (off == `NVM_OFF_EVADDR);
    end
  endfunction

  function ns_readable;
    input [7:0] off;
    begin
      ns_readable = (off == `NVM_OFF_CTRL1) || (off == `NVM_OFF_CTRLB) ||
                    (off == `NVM_OFF_CTRL3) || (off == `NVM_OFF_IFLAG) ||
                    (off == `NVM_OFF_STATUS);
    end
  endfunction

  function ns_writable;
    input [7:0] off;
    begin
      ns_writable = (off == `NVM_OFF_CTRL1) || (off == `NVM_OFF_CTRL3) ||
                    (off == `NVM_OFF_IFLAG);
    end
  endfunction

  function in_ns_region;
    input [23:0] a;
    begin
      in_ns_region = ((a >= NS_APP_LO) && (a < NS_APP_HI)) ||
                     ((a >= NS_DATA_LO) && (a < NS_DATA_HI));
    end
  endfunction

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [3:0]  wait_states_r;
  reg        cache_dis_r;
  reg [3:0]  ctrl3_r;
  reg        nswe_r;
  reg [23:0] evaddr_r;
  reg [1:0]  flag_r;
  reg        discard_r;
  reg        state_r;
  reg        tamper_pend_r;
  reg        autow_pend_r;
  reg        start_r;
  reg [7:0]  cmd_r;
  reg [23:0] addr_r;
  reg        dsel_r;
  reg        cache_bypass_r;
  reg [31:0] prdata_r;
  reg        pslverr_r;
  reg [31:0] pb_mem [0:PB_WORDS-1];
  reg [31:0] pb_rd_r;
  reg        pb_wr_pend_r;
  reg [PB_IDX_W-1:0] pb_wr_idx_r;
  reg        pb_err1_r;
  reg        pb_err2_r;

  // --------------------------------------------------------------------------
  // apb access qualification
  // --------------------------------------------------------------------------
  wire       ns        = (SECURE_EXT != 0) & pprot_i[1];
  wire       setup     = psel_i & ~penable_i;
  wire       access    = psel_i & penable_i;
  wire       mapped    = is_mapped(paddr_i);
  // a rejected non-secure write is dropped without a bus error
  wire       ns_block  = ns & (~nswe_r | ~ns_writable(paddr_i));
  // flags and status stay writable whatever the access controller says
  wire       acc_block = acc_wprot_i & (paddr_i != `NVM_OFF_IFLAG) &
                         (paddr_i != `NVM_OFF_STATUS);
  wire       wr_ok     = access & pwrite_i & mapped & ~ns_block & ~acc_block;
  wire       wr_drop   = access & pwrite_i & mapped & ns_block;

  wire [7:0]  sw_cmd  = pwdata_i[`NVM_CTRL1_CMD_MSB:`NVM_CTRL1_CMD_LSB];
  wire [23:0] sw_addr = pwdata_i[`NVM_CTRL1_ADDR_MSB:`NVM_CTRL1_ADDR_LSB];
  wire        sw_legal = (sw_cmd == `NVM_CMD_WP) || (sw_cmd == `NVM_CMD_ER) ||
                         (sw_cmd == `NVM_CMD_LOCK) || (sw_cmd == `NVM_CMD_UNLOCK);
  // non-secure commands outside the non-secure regions are ignored
  wire        sw_req  = wr_ok & (paddr_i == `NVM_OFF_CTRL1) & sw_legal &
                        (~ns | in_ns_region(sw_addr));

  // --------------------------------------------------------------------------
  // event inputs
  // --------------------------------------------------------------------------
  wire tamper_trig;
  wire autow_trig;

  nvm_event_edge u_tamper_edge (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .event_async_i (tamper_event_i),
    .invert_i      (ctrl3_r[`NVM_CTRL3_EVINV]),
    .trigger_o     (tamper_trig)
  );

  nvm_event_edge u_autow_edge (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .event_async_i (autow_event_i),
    .invert_i      (ctrl3_r[`NVM_CTRL3_EVINV]),
    .trigger_o     (autow_trig)
  );

  wire tamper_set = tamper_trig & ctrl3_r[`NVM_CTRL3_TAMPER_EN];
  wire autow_set  = autow_trig & ctrl3_r[`NVM_CTRL3_AUTOW_EN];

  // --------------------------------------------------------------------------
  // operation launcher
  // --------------------------------------------------------------------------
  // events outrank software; a command that cannot start is flagged, not queued
  wire idle          = (state_r == ST_IDLE);
  wire launch_tamper = idle & tamper_pend_r;
  wire launch_autow  = idle & ~tamper_pend_r & autow_pend_r;
  wire launch_sw     = idle & ~tamper_pend_r & ~autow_pend_r & sw_req;
  wire sw_refused    = sw_req & ~launch_sw;
  wire launch        = launch_tamper | launch_autow | launch_sw;
  wire op_end        = (state_r == ST_BUSY) & flash_done_i;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r       <= ST_IDLE;
      tamper_pend_r <= 1'b0;
      autow_pend_r  <= 1'b0;
      start_r       <= 1'b0;
      cmd_r         <= `NVM_CMD_NONE;
      addr_r        <= 24'h000000;
      dsel_r        <= 1'b0;
    end else begin
      // a new trigger in the launch cycle is kept pending
      tamper_pend_r <= tamper_set | (tamper_pend_r & ~launch_tamper);
      autow_pend_r  <= autow_set | (autow_pend_r & ~launch_autow);
      start_r       <= launch;
      case (state_r)
        ST_IDLE: begin
          if (launch_tamper) begin
            cmd_r   <= `NVM_CMD_TAMPER;
            addr_r  <= evaddr_r;
            dsel_r  <= 1'b1;
            state_r <= ST_BUSY;
          end else if (launch_autow) begin
            cmd_r   <= `NVM_CMD_WP;
            addr_r  <= evaddr_r;
            dsel_r  <= ctrl3_r[`NVM_CTRL3_AUTOW_DF];
            state_r <= ST_BUSY;
          end else if (launch_sw) begin
            cmd_r   <= sw_cmd;
            addr_r  <= sw_addr;
            dsel_r  <= (sw_addr >= DATA_BASE);
            state_r <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (flash_done_i) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  wire done_set  = op_end;
  wire err_set   = (op_end & flash_fail_i) | sw_refused;
  wire flag_wr   = wr_ok & (paddr_i == `NVM_OFF_IFLAG);
  wire stat_wr   = wr_ok & (paddr_i == `NVM_OFF_STATUS);
  wire pb_drop;
  wire [1:0] flag_clr = flag_wr ? pwdata_i[1:0] : 2'h0;
  wire [1:0] flag_set = {err_set, done_set};

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_states_r <= `NVM_CTRLB_RST;
      cache_dis_r   <= 1'b0;
      ctrl3_r       <= `NVM_CTRL3_RST;
      nswe_r        <= `NVM_NSCFG_RST;
      evaddr_r      <= `NVM_EVADDR_RST;
      flag_r        <= 2'h0;
      discard_r     <= 1'b0;
    end else begin
      if (wr_ok && (paddr_i == `NVM_OFF_CTRLB)) begin
        // takes effect at once; software owns ordering against clock changes
        wait_states_r <= pwdata_i[`NVM_CTRLB_WS_MSB:`NVM_CTRLB_WS_LSB];
        cache_dis_r   <= pwdata_i[`NVM_CTRLB_CACHEDIS];
      end
      if (wr_ok && (paddr_i == `NVM_OFF_CTRL3)) begin
        ctrl3_r <= pwdata_i[3:0];
      end
      if (wr_ok && (paddr_i == `NVM_OFF_NSCFG)) begin
        nswe_r <= pwdata_i[`NVM_NSCFG_WRITE];
      end
      if (wr_ok && (paddr_i == `NVM_OFF_EVADDR)) begin
        evaddr_r <= pwdata_i[23:0];
      end
      // write-one-to-clear; a simultaneous hardware set wins
      flag_r    <= flag_set | (flag_r & ~flag_clr);
      discard_r <= wr_drop | pb_drop |
                   (discard_r & ~(stat_wr & pwdata_i[`NVM_STAT_DISCARD]));
    end
  end

  // --------------------------------------------------------------------------
  // apb read data and error, captured in the setup cycle
  // --------------------------------------------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr_i)
      `NVM_OFF_CTRL1:   rd_mux = {addr_r, cmd_r};
      `NVM_OFF_CTRLB:   rd_mux = {23'h0, cache_dis_r, 4'h0, wait_states_r};
      `NVM_OFF_CTRL3:   rd_mux = {28'h0, ctrl3_r};
      `NVM_OFF_IFLAG:   rd_mux = {30'h0, flag_r};
      `NVM_OFF_STATUS:  rd_mux = {30'h0, discard_r, ~idle};
      `NVM_OFF_NSCFG:   rd_mux = {31'h0, nswe_r};
      `NVM_OFF_EVADDR:  rd_mux = {8'h00, evaddr_r};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      // reads of mapped offsets succeed; the non-secure alias hides secure-only registers
      prdata_r  <= (ns && !ns_readable(paddr_i)) ? 32'h00000000 : rd_mux;
      // only unmapped offsets and protected writes raise an error
      pslverr_r <= ~mapped | (pwrite_i & ~ns_block & acc_block);
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = pslverr_r & access;

  // --------------------------------------------------------------------------
  // ahb page buffer
  // --------------------------------------------------------------------------
  wire pb_addr_ph = pb_hsel_i & pb_htrans_i[1] & pb_hwrite_i & pb_hready_i;
  // a discarded non-secure buffer write gets the two-cycle error reply
  assign pb_drop  = pb_addr_ph & (SECURE_EXT != 0) & pb_hnonsec_i & ~nswe_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pb_wr_pend_r <= 1'b0;
      pb_wr_idx_r  <= {PB_IDX_W{1'b0}};
      pb_err1_r    <= 1'b0;
      pb_err2_r    <= 1'b0;
      pb_rd_r      <= 32'h00000000;
    end else begin
      pb_wr_pend_r <= pb_addr_ph & ~pb_drop;
      pb_err1_r    <= pb_drop;
      pb_err2_r    <= pb_err1_r;
      pb_rd_r      <= pb_mem[pb_rd_idx_i];
      if (pb_addr_ph) begin
        pb_wr_idx_r <= pb_haddr_i[PB_IDX_W+1:2];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PB_WORDS; gi = gi + 1) begin : g_pb
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pb_mem[gi] <= 32'h00000000;
        end else if (pb_wr_pend_r && (pb_wr_idx_r == gi)) begin
          pb_mem[gi] <= pb_hwdata_i;
        end
      end
    end
  endgenerate

  assign pb_hreadyout_o = ~pb_err1_r;
  assign pb_hresp_o     = pb_err1_r | pb_err2_r;
  assign pb_rd_data_o   = pb_rd_r;

  // --------------------------------------------------------------------------
  // read path control
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cache_bypass_r <= 1'b0;
    end else begin
      // debug reads must not disturb what the cache holds
      cache_bypass_r <= debug_halt_i | cache_dis_r;
    end
  end

  assign cache_bypass_o   = cache_bypass_r;
  assign wait_states_o    = wait_states_r;
  assign flash_start_o    = start_r;
  assign flash_cmd_o      = cmd_r;
  assign flash_addr_o     = addr_r;
  assign flash_data_sel_o = dsel_r;

endmodule

`default_nettype wire

// ---- nvm_access_defs.vh ----
`ifndef NVM_ACCESS_DEFS_VH
`define NVM_ACCESS_DEFS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define NVM_OFF_CTRL1    8'h00
`define NVM_OFF_CTRLB    8'h04
`define NVM_OFF_CTRL3    8'h08
`define NVM_OFF_IFLAG    8'h0C
`define NVM_OFF_STATUS   8'h10
`define NVM_OFF_NSCFG    8'h18
`define NVM_OFF_EVADDR   8'h1C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define NVM_CTRL1_CMD_MSB   7
`define NVM_CTRL1_CMD_LSB   0
`define NVM_CTRL1_ADDR_MSB  31
`define NVM_CTRL1_ADDR_LSB  8
`define NVM_CTRLB_WS_MSB    3
`define NVM_CTRLB_WS_LSB    0
`define NVM_CTRLB_CACHEDIS  8
`define NVM_CTRL3_TAMPER_EN 0
`define NVM_CTRL3_AUTOW_EN  1
`define NVM_CTRL3_AUTOW_DF  2
`define NVM_CTRL3_EVINV     3
`define NVM_FLAG_DONE       0
`define NVM_FLAG_ERROR      1
`define NVM_STAT_BUSY       0
`define NVM_STAT_DISCARD    1
`define NVM_NSCFG_WRITE     0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define NVM_CTRLB_RST   4'h0
`define NVM_CTRL3_RST   4'h0
`define NVM_NSCFG_RST   1'b0
`define NVM_EVADDR_RST  24'h000000

// ----------------------------------------------------------------------------
// flash operation codes
// ----------------------------------------------------------------------------
`define NVM_CMD_NONE    8'h00
`define NVM_CMD_WP      8'h01
`define NVM_CMD_ER      8'h02
`define NVM_CMD_LOCK    8'h03
`define NVM_CMD_UNLOCK  8'h04
`define NVM_CMD_TAMPER  8'h05

`endif

// ---- nvm_event_edge.v ----
`timescale 1ns/1ps
`default_nettype none

module nvm_event_edge (
  // clock and reset
  input  wire clk_i,
  input  wire reset_n_i,
  // event line and selection
  input  wire event_async_i,
  input  wire invert_i,
  output wire trigger_o
);

  reg sync1_r;
  reg sync2_r;
  reg level_prev_r;

  wire level = sync2_r ^ invert_i;

  // the event comes unsynchronised from the asynchronous channel path
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r      <= 1'b0;
      sync2_r      <= 1'b0;
      level_prev_r <= 1'b0;
    end else begin
      sync1_r      <= event_async_i;
      sync2_r      <= sync1_r;
      level_prev_r <= level;
    end
  end

  // rising edge of the (optionally inverted) line gives one pulse
  assign trigger_o = level & ~level_prev_r;

endmodule

`default_nettype wire

// ---- nvm_access_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_defs.vh"
module nvm_access_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // apb slave
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [2:0]  pprot_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // page buffer and system
  input wire logic        pb_hreadyout_o,
  input wire logic        pb_hresp_o,
  input wire logic        acc_wprot_i,
  input wire logic        debug_halt_i,
  // flash and timing
  input wire logic        flash_start_o,
  input wire logic [7:0]  flash_cmd_o,
  input wire logic        flash_data_sel_o,
  input wire logic        cache_bypass_o,
  input wire logic [3:0]  wait_states_o
);
  logic [3:0] ws_req;
  assign ws_req = pwdata_i[3:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // steps of a transfer
  // ----------------------------------------
  sequence apb_wr_s;
    psel_i && penable_i && pwrite_i;
  endsequence
  sequence ctrlb_set_s;
    apb_wr_s ##0 (paddr_i == `NVM_OFF_CTRLB && !pprot_i[1] && !acc_wprot_i);
  endsequence
  sequence err_reply_s;
    (!pb_hreadyout_o && pb_hresp_o) ##1 (pb_hreadyout_o && pb_hresp_o);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  ready_always_a: assert property (pready_o)
    else $error("apb ready dropped");
  wait_state_a: assert property (ctrlb_set_s |=> wait_states_o == $past(ws_req))
    else $error("wait states not taken from write");
  cache_debug_a: assert property (debug_halt_i |=> cache_bypass_o)
    else $error("cache not bypassed in debug halt");
  acc_block_a: assert property (apb_wr_s ##0 (acc_wprot_i && paddr_i == `NVM_OFF_CTRLB)
    |-> pslverr_o) else $error("protected write without error");
  flag_open_a: assert property (apb_wr_s ##0 (paddr_i == `NVM_OFF_IFLAG ||
    paddr_i == `NVM_OFF_STATUS) |-> !pslverr_o) else $error("flag write refused");
  ns_silent_a: assert property (apb_wr_s ##0 (pprot_i[1] && !acc_wprot_i &&
    paddr_i == `NVM_OFF_CTRLB) |-> !pslverr_o) else $error("non-secure drop not silent");
  err_gate_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("apb error outside access");
  ahb_fault_a: assert property ($rose(pb_hresp_o) |-> err_reply_s)
    else $error("page buffer error reply malformed");
  start_pulse_a: assert property (flash_start_o |=> !flash_start_o)
    else $error("flash start longer than one cycle");
  tamper_sel_a: assert property (flash_start_o && flash_cmd_o == `NVM_CMD_TAMPER
    |-> flash_data_sel_o) else $error("tamper erase not on data flash");
endmodule
bind nonvolatile_memory_controller nvm_access_props props_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pprot_i(pprot_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pb_hreadyout_o(pb_hreadyout_o),
  .pb_hresp_o(pb_hresp_o), .acc_wprot_i(acc_wprot_i), .debug_halt_i(debug_halt_i),
  .flash_start_o(flash_start_o), .flash_cmd_o(flash_cmd_o),
  .flash_data_sel_o(flash_data_sel_o), .cache_bypass_o(cache_bypass_o),
  .wait_states_o(wait_states_o));
`default_nettype wire

// ---- flash_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
  parameter int DELAY = 4
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // operation handshake
  input  wire logic start_i,
  output logic      done_o,
  output logic      fail_o
);
  logic [7:0] cnt_r;
  // the array never reports a failed operation here
  assign fail_o = 1'b0;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r  <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_r == 8'h01);
      if (start_i) begin
        cnt_r <= 8'(DELAY);
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- nvm_access_protection_events_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_defs.vh"
module nvm_access_protection_events_tb;
  localparam [23:0] APP_LO = 24'h002000;
  localparam [23:0] DATA_LO = 24'h400400;
  logic clk_i, reset_n_i, psel, penable, pwrite, rerr, herr, fdone, ffail;
  logic hsel, hnonsec, acc_wprot, debug_halt, tamper_ev, autow_ev;
  logic [1:0] htrans;
  logic [2:0] pprot;
  logic [3:0] rd_idx;
  logic [7:0] paddr, last_cmd;
  logic [23:0] last_addr;
  logic last_sel;
  logic [31:0] pwdata, rdata, haddr, hwdata;
  wire [31:0] prdata, pb_rd_data, ws_w, cb_w;
  wire pready, pslverr, hreadyout, hresp, fstart, fsel, cbyp;
  wire [7:0] fcmd;
  wire [23:0] faddr;
  wire [3:0] ws;
  int miscompares = 0, comparisons = 0, starts = 0, cycles = 0;
  nonvolatile_memory_controller #(.NS_APP_LO(APP_LO), .NS_DATA_LO(DATA_LO)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pprot_i(pprot),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pb_hsel_i(hsel),
    .pb_htrans_i(htrans), .pb_hwrite_i(1'b1), .pb_haddr_i(haddr), .pb_hnonsec_i(hnonsec),
    .pb_hwdata_i(hwdata), .pb_hready_i(1'b1), .pb_hreadyout_o(hreadyout),
    .pb_hresp_o(hresp), .pb_rd_idx_i(rd_idx), .pb_rd_data_o(pb_rd_data),
    .acc_wprot_i(acc_wprot), .debug_halt_i(debug_halt), .tamper_event_i(tamper_ev),
    .autow_event_i(autow_ev), .flash_start_o(fstart), .flash_cmd_o(fcmd),
    .flash_addr_o(faddr), .flash_data_sel_o(fsel), .flash_done_i(fdone),
    .flash_fail_i(ffail), .cache_bypass_o(cbyp), .wait_states_o(ws));
  flash_array_model #(.DELAY(4)) flash_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .start_i(fstart), .done_o(fdone), .fail_o(ffail));
  assign ws_w = {28'h0, ws};
  assign cb_w = {31'h0, cbyp};
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task end_sim;
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ns);
    int k;
    k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin @(posedge clk_i); k++; end while (pready !== 1'b1 && k < 50);
    check("apb ready", pready, 32'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task ahb(input logic [31:0] a, input logic [31:0] d, input logic ns);
    int k;
    k = 0;
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hnonsec <= ns;
    @(posedge clk_i);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    herr = 1'b0;
    do begin @(posedge clk_i); herr |= hresp; k++; end while (hreadyout !== 1'b1 && k < 20);
    check("ahb ready", hreadyout, 32'h1);
    rd_idx <= a[5:2];
    repeat (2) @(posedge clk_i);
  endtask
  // waits for the n-th launch, then for the controller to go idle
  task op_wait(input int n);
    int k;
    k = 0;
    while (starts != n && k < 40) begin @(posedge clk_i); k++; end
    check("launch count", starts, n);
    do apb(1'b0, `NVM_OFF_STATUS, 32'h0, 1'b0); while (rdata[0] !== 1'b0 && ++k < 80);
    check("op idle", rdata[0], 32'h0);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (fstart === 1'b1) begin
      starts <= starts + 1; last_cmd <= fcmd; last_addr <= faddr; last_sel <= fsel;
    end
    if (cycles == 6000) begin miscompares++; end_sim(); end
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n_i, psel, penable, pwrite, hsel, hnonsec, acc_wprot, debug_halt} = '0;
    {tamper_ev, autow_ev, htrans, pprot, rd_idx, paddr, pwdata, haddr, hwdata} = '0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    apb(1'b0, `NVM_OFF_NSCFG, 32'h0, 1'b0); check("nscfg reset", rdata, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 1'b0); check("unmapped error", rerr, 32'h1);
    apb(1'b1, `NVM_OFF_CTRLB, 32'h00000105, 1'b0); check("wait states", ws_w, 32'h5);
    repeat (2) @(posedge clk_i); check("cache disable", cb_w, 32'h1);
    apb(1'b1, `NVM_OFF_CTRLB, 32'h00000003, 1'b0); debug_halt <= 1'b1;
    repeat (2) @(posedge clk_i); check("debug bypass", cb_w, 32'h1);
    acc_wprot <= 1'b1;
    apb(1'b1, `NVM_OFF_CTRLB, 32'h00000007, 1'b0); check("protected err", rerr, 32'h1);
    check("protected kept", ws_w, 32'h3);
    apb(1'b1, `NVM_OFF_IFLAG, 32'h0, 1'b0); check("flag write err", rerr, 32'h0);
    acc_wprot <= 1'b0;
    apb(1'b1, `NVM_OFF_CTRL3, 32'h00000004, 1'b1); check("ns drop err", rerr, 32'h0);
    apb(1'b0, `NVM_OFF_CTRL3, 32'h0, 1'b0); check("ns drop ctrl3", rdata, 32'h0);
    apb(1'b0, `NVM_OFF_STATUS, 32'h0, 1'b0); check("discard seen", rdata[1], 32'h1);
    apb(1'b1, `NVM_OFF_NSCFG, 32'h00000001, 1'b0);
    apb(1'b1, `NVM_OFF_CTRLB, 32'h0000000F, 1'b1); check("ns ctrlb err", rerr, 32'h0);
    apb(1'b0, `NVM_OFF_CTRLB, 32'h0, 1'b0); check("ns ctrlb kept", rdata, 32'h3);
    apb(1'b1, `NVM_OFF_CTRL3, 32'h00000004, 1'b1);
    apb(1'b0, `NVM_OFF_CTRL3, 32'h0, 1'b1); check("ns ctrl3", rdata, 32'h4);
    apb(1'b0, `NVM_OFF_NSCFG, 32'h0, 1'b1); check("ns hidden", rdata, 32'h0);
    apb(1'b0, `NVM_OFF_NSCFG, 32'h0, 1'b0); check("secure view", rdata, 32'h1);
    apb(1'b1, `NVM_OFF_CTRL1, {24'h000100, `NVM_CMD_WP}, 1'b1);
    repeat (6) @(posedge clk_i); check("ns outside", starts, 32'h0);
    for (int i = 1; i <= 4; i++) begin
      apb(1'b1, `NVM_OFF_CTRL1, {(i[0] ? APP_LO : DATA_LO) + 24'h40, i[7:0]}, 1'b1);
      op_wait(i);
      check("ns cmd", last_cmd, i);
      check("ns addr", last_addr, (i[0] ? APP_LO : DATA_LO) + 24'h40);
    end
    apb(1'b0, `NVM_OFF_IFLAG, 32'h0, 1'b0); check("done flag", rdata[0], 32'h1);
    apb(1'b1, `NVM_OFF_IFLAG, 32'h00000001, 1'b0);
    apb(1'b0, `NVM_OFF_IFLAG, 32'h0, 1'b0); check("done clear", rdata[0], 32'h0);
    apb(1'b1, `NVM_OFF_EVADDR, {8'h00, DATA_LO}, 1'b0);
    apb(1'b1, `NVM_OFF_CTRL3, 32'h00000001, 1'b0);
    tamper_ev <= 1'b1;
    op_wait(5); check("tamper cmd", last_cmd, `NVM_CMD_TAMPER);
    check("tamper sel", last_sel, 32'h1); check("tamper addr", last_addr, DATA_LO);
    tamper_ev <= 1'b0;
    apb(1'b1, `NVM_OFF_CTRL3, 32'h00000006, 1'b0);
    autow_ev <= 1'b1;
    op_wait(6); check("auto cmd", last_cmd, `NVM_CMD_WP); check("auto df", last_sel, 32'h1);
    autow_ev <= 1'b0;
    apb(1'b1, `NVM_OFF_CTRL3, 32'h00000002, 1'b0);
    autow_ev <= 1'b1;
    op_wait(7); check("auto main", last_sel, 32'h0);
    apb(1'b1, `NVM_OFF_CTRL3, 32'h0000000A, 1'b0);
    repeat (6) @(posedge clk_i); check("invert no edge", starts, 32'h7);
    autow_ev <= 1'b0;
    op_wait(8); check("falling trigger", last_cmd, `NVM_CMD_WP);
    apb(1'b1, `NVM_OFF_NSCFG, 32'h0, 1'b0);
    ahb(32'h8, 32'hA5A5A5A5, 1'b0); check("pb secure", herr, 32'h0);
    ahb(32'h8, 32'h5A5A5A5A, 1'b1); check("pb ns fault", herr, 32'h1);
    check("pb kept", pb_rd_data, 32'hA5A5A5A5);
    apb(1'b1, `NVM_OFF_NSCFG, 32'h00000001, 1'b0);
    ahb(32'h8, 32'h5A5A5A5A, 1'b1); check("pb ns ok", herr, 32'h0);
    check("pb ns data", pb_rd_data, 32'h5A5A5A5A);
    apb(1'b1, `NVM_OFF_CTRL1, {DATA_LO, `NVM_CMD_ER}, 1'b0);
    apb(1'b1, `NVM_OFF_CTRL1, {DATA_LO, `NVM_CMD_ER}, 1'b0);
    op_wait(9);
    apb(1'b0, `NVM_OFF_IFLAG, 32'h0, 1'b0); check("refused err", rdata[1], 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
